// [src/sac_pkg.sv]
// shared constants and types for the serial converter control block
// What this block does
// - negative supply below ground selects bipolar
// - low reference forces reference ready flag low
// - unipolar result is straight binary code
// - bipolar result is two's complement code
// - after reset device is active and ready
// - clock low, two start pulses: nap
// - clock low, four start pulses: sleep
// - nap keeps only the reference powered
// - sleep powers down everything including reference
// - clock rising edge wakes from nap/sleep
// - ready to convert 350ns after nap wake
// - after sleep wake flag waits reference settling
// - reference ready flag precedes result bits
// - start edges ignored while converting
// - start too close to clock delays output
// - output changes on each clock rising edge
// - host samples data on clock rising edge
// - word: three zeros, flag, D11..D0
// - host waits during conversion
// - host recovers with a nap request
// - host drops start within 120ns
package sac_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int START_TO_CLK_NS = 300;
  localparam int START_TO_CLK_CYC =
    (START_TO_CLK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NAP_WAKE_NS = 350;
  localparam int NAP_WAKE_CYC =
    (NAP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REF_SETTLE_US = 4000;
  localparam int REF_SETTLE_CYC = REF_SETTLE_US * 1000 / CLK_PERIOD_NS;
  localparam int CONV_HIGH_MAX_NS = 120;
  localparam int CONV_HIGH_CYC = CONV_HIGH_MAX_NS / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYC = 4;
  localparam int HOST_LEAD_CYC = START_TO_CLK_CYC + 2;
  localparam int PULSE_GAP_CYC = 4;
  localparam int WORD_BITS = 16;
  localparam int RESULT_BITS = 12;
  localparam int FLAG_POS = 12;
  localparam logic [2:0] NAP_PULSES = 3'h2;
  localparam logic [2:0] SLEEP_PULSES = 3'h4;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam int CTRL_CONVERT = 0;
  localparam int CTRL_NAP = 1;
  localparam int CTRL_SLEEP = 2;
  localparam int CTRL_WAKE = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_VALID = 1;
  typedef enum logic [1:0] {PWR_ACTIVE, PWR_NAP, PWR_SLEEP} sac_pwr_t;
endpackage

// [src/sac_link_if.sv]
// three-wire link between converter and host
`timescale 1ns/10ps
interface sac_link_if;
  logic sclk;
  logic conv;
  logic dout;
  modport dev (input sclk, input conv, output dout);
  modport host (output sclk, output conv, input dout);
endinterface

// [src/sac_sync.sv]
// two-flop synchroniser for asynchronous inputs
`timescale 1ns/10ps
module sac_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_r;
  initial begin
    if (W < 1) $error("sac_sync width must be positive");
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_r <= '0;
      q_out <= '0;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule

// [src/sac_device.sv]
// converter end: conversion control, serial output and power modes
`timescale 1ns/10ps
module sac_device import sac_pkg::*; #(
  parameter int REF_SETTLE = REF_SETTLE_CYC,
  parameter int T2_CYC = START_TO_CLK_CYC
) (
  // system
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  // link
  sac_link_if.dev LINK,
  // analog stand-ins
  input wire logic [RESULT_BITS-1:0] ADC_SAMPLE_IN,
  input wire logic VSS_NEG_IN,
  input wire logic VREF_LOW_IN,
  // status
  output logic [1:0] PWR_STATE_OUT,
  output logic CORE_ON_OUT,
  output logic REF_ON_OUT,
  output logic BIPOLAR_OUT,
  output logic REF_READY_OUT,
  output logic BUSY_OUT
);
  initial begin
    if (REF_SETTLE < 1 || REF_SETTLE > 65535)
      $error("REF_SETTLE out of range");
    if (T2_CYC < 1 || T2_CYC > 255) $error("T2_CYC out of range");
  end

  logic [RESULT_BITS+3:0] raw_s;
  logic [RESULT_BITS-1:0] sample_s;
  logic sclk_s, conv_s, vss_neg_s, vref_low_s;
  logic sclk_d_r, conv_d_r;
  logic sclk_rise, conv_rise;
  sac_pwr_t pwr_r, pwr_nxt;
  logic [2:0] pulse_cnt_r;
  logic [15:0] settle_cnt_r;
  logic ref_settled_r;
  logic [2:0] wake_cnt_r;
  logic busy_r;
  logic [4:0] bit_cnt_r;
  logic [7:0] t2_cnt_r;
  logic first_r;
  logic [WORD_BITS-1:0] word_r;
  logic dout_r;
  logic enter_nap, enter_sleep, start_ok, shift_ok;
  logic [RESULT_BITS-1:0] code;

  // all pins come from outside this clock
  sac_sync #(.W(RESULT_BITS + 4)) u_sync (
    .clk_in(SYS_CLK_IN),
    .rst_in(SYS_RST_IN),
    .d_in({ADC_SAMPLE_IN, VREF_LOW_IN, VSS_NEG_IN,
           LINK.conv, LINK.sclk}),
    .q_out(raw_s)
  );
  assign sample_s = raw_s[RESULT_BITS+3:4];
  assign vref_low_s = raw_s[3];
  assign vss_neg_s = raw_s[2];
  assign conv_s = raw_s[1];
  assign sclk_s = raw_s[0];

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      sclk_d_r <= 1'b0;
      conv_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      conv_d_r <= conv_s;
    end
  end
  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign conv_rise = conv_s & ~conv_d_r;

  // pulses only count with the clock held low
  assign enter_nap = conv_rise & ~sclk_s & pwr_r == PWR_ACTIVE &
    pulse_cnt_r == NAP_PULSES - 3'h1;
  assign enter_sleep = conv_rise & ~sclk_s & pwr_r == PWR_NAP &
    pulse_cnt_r == SLEEP_PULSES - 3'h1;

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      pulse_cnt_r <= 3'h0;
    end else if (sclk_rise) begin
      pulse_cnt_r <= 3'h0;
    end else if (conv_rise && !sclk_s && pulse_cnt_r != SLEEP_PULSES) begin
      pulse_cnt_r <= pulse_cnt_r + 3'h1;
    end
  end

  always_comb begin
    pwr_nxt = pwr_r;
    if (sclk_rise && pwr_r != PWR_ACTIVE) begin
      pwr_nxt = PWR_ACTIVE;
    end else if (enter_sleep) begin
      pwr_nxt = PWR_SLEEP;
    end else if (enter_nap) begin
      pwr_nxt = PWR_NAP;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      pwr_r <= PWR_ACTIVE;
      CORE_ON_OUT <= 1'b1;
      REF_ON_OUT <= 1'b1;
      PWR_STATE_OUT <= 2'h0;
    end else begin
      pwr_r <= pwr_nxt;
      PWR_STATE_OUT <= pwr_nxt;
      CORE_ON_OUT <= pwr_nxt == PWR_ACTIVE;
      REF_ON_OUT <= pwr_nxt != PWR_SLEEP;
    end
  end

  // nap wake delay before a start is honoured
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      wake_cnt_r <= 3'h0;
    end else if (sclk_rise && pwr_r == PWR_NAP) begin
      wake_cnt_r <= 3'(NAP_WAKE_CYC);
    end else if (wake_cnt_r != 3'h0) begin
      wake_cnt_r <= wake_cnt_r - 3'h1;
    end
  end

  // reference settling after sleep
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      settle_cnt_r <= 16'h0000;
      ref_settled_r <= 1'b1;
    end else if (pwr_r == PWR_SLEEP) begin
      ref_settled_r <= 1'b0;
      settle_cnt_r <= 16'(REF_SETTLE);
    end else if (settle_cnt_r != 16'h0000) begin
      settle_cnt_r <= settle_cnt_r - 16'h0001;
      ref_settled_r <= settle_cnt_r == 16'h0001;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      REF_READY_OUT <= 1'b0;
      BIPOLAR_OUT <= 1'b0;
    end else begin
      // flag falls with the sleep state itself, not a cycle behind it
      REF_READY_OUT <= ref_settled_r & ~vref_low_s &
        pwr_nxt != PWR_SLEEP;
      BIPOLAR_OUT <= vss_neg_s;
    end
  end

  // bipolar flips the msb of the offset code
  assign code = vss_neg_s ? {~sample_s[RESULT_BITS-1],
    sample_s[RESULT_BITS-2:0]} : sample_s;

  assign start_ok = conv_rise & ~busy_r & pwr_r == PWR_ACTIVE &
    wake_cnt_r == 3'h0 & ~enter_nap;
  // only the first rise after a start can come too early
  assign shift_ok = sclk_rise & busy_r &
    ~(first_r & t2_cnt_r < 8'(T2_CYC));

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      busy_r <= 1'b0;
      bit_cnt_r <= 5'h00;
      first_r <= 1'b0;
      t2_cnt_r <= 8'h00;
      word_r <= '0;
      dout_r <= 1'b0;
    end else if (pwr_nxt != PWR_ACTIVE) begin
      // a power-down drops any word in flight
      busy_r <= 1'b0;
      dout_r <= 1'b0;
    end else if (start_ok) begin
      busy_r <= 1'b1;
      bit_cnt_r <= 5'h00;
      first_r <= 1'b1;
      t2_cnt_r <= 8'h00;
      word_r <= {3'b000, ref_settled_r & ~vref_low_s, code};
      dout_r <= 1'b0;
    end else if (busy_r) begin
      if (t2_cnt_r != 8'hFF) begin
        t2_cnt_r <= t2_cnt_r + 8'h01;
      end
      if (sclk_rise) begin
        first_r <= 1'b0;
      end
      if (shift_ok) begin
        dout_r <= word_r[WORD_BITS-1];
        word_r <= {word_r[WORD_BITS-2:0], 1'b0};
        bit_cnt_r <= bit_cnt_r + 5'h01;
        busy_r <= bit_cnt_r != 5'(WORD_BITS - 1);
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      BUSY_OUT <= 1'b0;
    end else begin
      // registered copy, so it trails busy_r by a cycle
      BUSY_OUT <= busy_r;
    end
  end

  assign LINK.dout = dout_r;
endmodule

// [src/sac_host.sv]
// host end: drives clock and start, collects words, register port
`timescale 1ns/10ps
module sac_host import sac_pkg::*; (
  // system
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  // register port
  input wire logic [7:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  // link
  sac_link_if.host LINK
);
  typedef enum logic [3:0] {
    H_IDLE, H_CONV, H_LEAD, H_CLK_HI, H_CLK_LO,
    H_PULSE_HI, H_PULSE_LO, H_WAKE_HI, H_WAKE_WAIT
  } sac_hst_t;
  sac_hst_t st_r;
  logic [7:0] cnt_r;
  logic [4:0] edge_r;
  logic [2:0] pulses_r;
  logic sclk_r, conv_r, busy;
  logic valid_r;
  logic [WORD_BITS-1:0] shift_r, data_r;
  logic dout_s;
  logic wr_ctrl, rd_data, word_done;

  sac_sync #(.W(1)) u_sync (
    .clk_in(SYS_CLK_IN),
    .rst_in(SYS_RST_IN),
    .d_in(LINK.dout),
    .q_out(dout_s)
  );

  assign busy = st_r != H_IDLE;
  assign wr_ctrl = WR_IN & ADDR_IN == REG_CTRL & ~busy;
  assign rd_data = RD_IN & ADDR_IN == REG_DATA;
  assign word_done = st_r == H_CLK_LO & cnt_r == 8'h00 &
    edge_r == 5'(WORD_BITS + 1);

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      st_r <= H_IDLE;
      cnt_r <= 8'h00;
      edge_r <= 5'h00;
      pulses_r <= 3'h0;
      sclk_r <= 1'b0;
      conv_r <= 1'b0;
      shift_r <= '0;
    end else begin
      if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
      unique case (st_r)
        H_IDLE: begin
          // orders only taken while idle: a control write while busy is dropped
          if (wr_ctrl && WDATA_IN[CTRL_CONVERT]) begin
            conv_r <= 1'b1;
            st_r <= H_CONV;
          end else if (wr_ctrl && WDATA_IN[CTRL_SLEEP]) begin
            pulses_r <= SLEEP_PULSES;
            st_r <= H_PULSE_HI;
          end else if (wr_ctrl && WDATA_IN[CTRL_NAP]) begin
            pulses_r <= NAP_PULSES;
            st_r <= H_PULSE_HI;
          end else if (wr_ctrl && WDATA_IN[CTRL_WAKE]) begin
            sclk_r <= 1'b1;
            cnt_r <= 8'(SCLK_HALF_CYC - 1);
            st_r <= H_WAKE_HI;
          end
        end
        H_CONV: begin
          if (cnt_r == 8'h00) begin
            conv_r <= 1'b0;
            cnt_r <= 8'(HOST_LEAD_CYC);
            edge_r <= 5'h00;
            st_r <= H_LEAD;
          end
        end
        H_LEAD, H_CLK_LO: begin
          if (cnt_r == 8'h00) begin
            if (edge_r == 5'(WORD_BITS + 1)) begin
              st_r <= H_IDLE;
            end else begin
              sclk_r <= 1'b1;
              if (edge_r != 5'h00) begin
                shift_r <= {shift_r[WORD_BITS-2:0], dout_s};
              end
              edge_r <= edge_r + 5'h01;
              cnt_r <= 8'(SCLK_HALF_CYC - 1);
              st_r <= H_CLK_HI;
            end
          end
        end
        H_CLK_HI: begin
          if (cnt_r == 8'h00) begin
            sclk_r <= 1'b0;
            cnt_r <= 8'(SCLK_HALF_CYC - 1);
            st_r <= H_CLK_LO;
          end
        end
        H_PULSE_HI: begin
          conv_r <= 1'b1;
          cnt_r <= 8'(PULSE_GAP_CYC);
          pulses_r <= pulses_r - 3'h1;
          st_r <= H_PULSE_LO;
        end
        H_PULSE_LO: begin
          conv_r <= 1'b0;
          if (cnt_r == 8'h00) begin
            st_r <= pulses_r == 3'h0 ? H_IDLE : H_PULSE_HI;
          end
        end
        H_WAKE_HI: begin
          if (cnt_r == 8'h00) begin
            sclk_r <= 1'b0;
            cnt_r <= 8'(NAP_WAKE_CYC + 2);
            st_r <= H_WAKE_WAIT;
          end
        end
        H_WAKE_WAIT: begin
          if (cnt_r == 8'h00) begin
            st_r <= H_IDLE;
          end
        end
      endcase
    end
  end

  // a finished word beats a read of the data register
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      valid_r <= 1'b0;
      data_r <= '0;
    end else if (word_done) begin
      valid_r <= 1'b1;
      data_r <= shift_r;
    end else if (rd_data) begin
      valid_r <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      RDATA_OUT <= 32'h00000000;
    end else if (RD_IN && ADDR_IN == REG_STATUS) begin
      RDATA_OUT <= {30'h0, valid_r, busy};
    end else if (rd_data) begin
      RDATA_OUT <= {16'h0000, data_r};
    end else begin
      RDATA_OUT <= 32'h00000000;
    end
  end

  assign LINK.sclk = sclk_r;
  assign LINK.conv = conv_r;
endmodule

// [sim/sac_link_monitor.sv]
// concurrent checks on the converter link and the device power status
`timescale 1ns/10ps
module sac_link_monitor import sac_pkg::*; (
  // system
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  // link
  input wire logic sclk,
  input wire logic conv,
  input wire logic dout,
  // device status
  input wire logic [1:0] PWR_STATE_OUT,
  input wire logic CORE_ON_OUT,
  input wire logic REF_ON_OUT,
  input wire logic REF_READY_OUT,
  input wire logic BUSY_OUT
);
  logic sclk_d_r;
  logic conv_d_r;
  logic [3:0] rise_age_r;
  logic [2:0] pulse_cnt_r;

  always_ff @(posedge SYS_CLK_IN) begin
    sclk_d_r <= sclk;
    conv_d_r <= conv;
  end

  // saturates so an old clock rise never looks recent again
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      rise_age_r <= 4'hF;
    end else if (sclk && !sclk_d_r) begin
      rise_age_r <= 4'h0;
    end else if (rise_age_r != 4'hF) begin
      rise_age_r <= rise_age_r + 4'h1;
    end
  end

  // start pulses seen on the wire while the clock stays low
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      pulse_cnt_r <= 3'h0;
    end else if (sclk && !sclk_d_r) begin
      pulse_cnt_r <= 3'h0;
    end else if (conv && !conv_d_r && !sclk && pulse_cnt_r != 3'h7) begin
      pulse_cnt_r <= pulse_cnt_r + 3'h1;
    end
  end

  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  chk_active_core_on: assert property (
    PWR_STATE_OUT == 2'h0 |-> CORE_ON_OUT && REF_ON_OUT)
    else $error("core or reference off while active");
  chk_nap_ref_only: assert property (
    PWR_STATE_OUT == 2'h1 |-> REF_ON_OUT && !CORE_ON_OUT)
    else $error("nap power split wrong");
  chk_sleep_all_off: assert property (
    PWR_STATE_OUT == 2'h2 |-> !REF_ON_OUT && !CORE_ON_OUT && !REF_READY_OUT)
    else $error("sleep left something powered");
  chk_nap_two_pulses: assert property (
    PWR_STATE_OUT == 2'h1 && $past(PWR_STATE_OUT) == 2'h0
      |-> pulse_cnt_r == 3'h2)
    else $error("nap entered without two start pulses");
  chk_sleep_four_pulses: assert property (
    PWR_STATE_OUT == 2'h2 && $past(PWR_STATE_OUT) != 2'h2
      |-> pulse_cnt_r == 3'h4)
    else $error("sleep entered without four start pulses");
  chk_wake_on_rise: assert property (
    PWR_STATE_OUT != 2'h0 && $rose(sclk) |-> ##[1:8] PWR_STATE_OUT == 2'h0)
    else $error("clock rise did not wake the device");
  chk_wake_needs_rise: assert property (
    PWR_STATE_OUT == 2'h0 && $past(PWR_STATE_OUT) != 2'h0
      |-> rise_age_r <= 4'h8)
    else $error("device woke without a clock rise");
  chk_dout_after_rise: assert property (
    $changed(dout) && $past(BUSY_OUT) |-> rise_age_r inside {[2:6]})
    else $error("data line changed away from a clock rise");
  chk_word_lead_zeros: assert property (
    $rose(BUSY_OUT) |-> !dout [*8])
    else $error("word does not open with zero bits");
  chk_wake_ref_low: assert property (
    PWR_STATE_OUT == 2'h0 && $past(PWR_STATE_OUT) == 2'h2
      |-> !REF_READY_OUT)
    else $error("reference ready right at sleep wake");
endmodule

// [sim/sac_bench.sv]
// bench: both ends joined, driven through the host register port
`timescale 1ns/10ps
module sac_bench import sac_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [11:0] sample = 12'h000;
  logic vss_neg = 1'b0;
  logic vref_low = 1'b0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [1:0] pwr;
  logic core_on, ref_on, bipolar, ref_ready, busy;
  int fail_count = 0;
  int n_compared = 0;

  always #50 clk = ~clk;

  sac_link_if sac_link_if_i();
  // short settle keeps the sleep wake test brief
  sac_device #(.REF_SETTLE(50), .T2_CYC(START_TO_CLK_CYC)) sac_device_i (
    .SYS_CLK_IN(clk), .SYS_RST_IN(rst), .LINK(sac_link_if_i),
    .ADC_SAMPLE_IN(sample), .VSS_NEG_IN(vss_neg), .VREF_LOW_IN(vref_low),
    .PWR_STATE_OUT(pwr), .CORE_ON_OUT(core_on), .REF_ON_OUT(ref_on),
    .BIPOLAR_OUT(bipolar), .REF_READY_OUT(ref_ready), .BUSY_OUT(busy));
  sac_host sac_host_i (
    .SYS_CLK_IN(clk), .SYS_RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .LINK(sac_link_if_i));
  sac_link_monitor sac_link_monitor_i (
    .SYS_CLK_IN(clk), .SYS_RST_IN(rst), .sclk(sac_link_if_i.sclk),
    .conv(sac_link_if_i.conv), .dout(sac_link_if_i.dout),
    .PWR_STATE_OUT(pwr), .CORE_ON_OUT(core_on), .REF_ON_OUT(ref_on),
    .REF_READY_OUT(ref_ready), .BUSY_OUT(busy));

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic convert(input logic [11:0] s, input logic neg,
                         input logic low);
    logic [31:0] st;
    logic [31:0] w;
    logic [11:0] code;
    int n;
    sample <= s;
    vss_neg <= neg;
    vref_low <= low;
    repeat (6) @(posedge clk);
    chk(bipolar, neg, "bipolar");
    chk(ref_ready, !low, "ref_ready");
    wr_reg(REG_CTRL, 32'h1);
    repeat (5) @(posedge clk);
    chk(busy, 1'b1, "busy");
    n = 0;
    st = 32'h0;
    while (st[STAT_VALID] !== 1'b1 && n < 400) begin
      rd_reg(REG_STATUS, st);
      n++;
    end
    // two's complement is the offset code less half scale
    code = neg ? s - 12'h800 : s;
    rd_reg(REG_DATA, w);
    chk(w, {16'h0, 3'h0, !low, code}, "word");
    rd_reg(REG_STATUS, st);
    chk(st[STAT_VALID], 1'b0, "valid_clear");
    chk(busy, 1'b0, "busy_end");
    $display("conversion %h done", s);
  endtask

  task automatic power(input logic [31:0] cmd, input logic [1:0] p,
                       input logic core, input logic rf);
    wr_reg(REG_CTRL, cmd);
    repeat (40) @(posedge clk);
    chk(pwr, p, "pwr_state");
    chk(core_on, core, "core_on");
    chk(ref_on, rf, "ref_on");
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(pwr, 2'h0, "pwr_state");
    chk(core_on, 1'b1, "core_on");
    chk(ref_on, 1'b1, "ref_on");
    rd_reg(8'h0C, d);
    chk(d, 32'h0, "unmapped");
    rd_reg(REG_CTRL, d);
    chk(d, 32'h0, "ctrl_read");
    $display("test reset done");
    convert(12'hABC, 1'b0, 1'b0);
    convert(12'h000, 1'b0, 1'b0);
    convert(12'hFFF, 1'b1, 1'b0);
    convert(12'h123, 1'b1, 1'b1);
    convert(12'h800, 1'b0, 1'b1);
    $display("test coding done");
    power(32'h2, 2'h1, 1'b0, 1'b1);
    power(32'h8, 2'h0, 1'b1, 1'b1);
    convert(12'h5A5, 1'b0, 1'b0);
    $display("test nap done");
    power(32'h4, 2'h2, 1'b0, 1'b0);
    chk(ref_ready, 1'b0, "ref_ready");
    wr_reg(REG_CTRL, 32'h8);
    repeat (10) @(posedge clk);
    chk(pwr, 2'h0, "pwr_state");
    chk(ref_ready, 1'b0, "ref_ready");
    repeat (60) @(posedge clk);
    convert(12'h3C3, 1'b1, 1'b0);
    $display("test sleep done");
    results();
  end

  // whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("[ERR] watchdog expected finish seen hang");
    results();
  end
endmodule
